//--- logic/fms_pkg.sv
// Overview of operation
// - Group B bit 7 holds latched discharge short-circuit failure.
// - Group B bit 4 holds active imbalance, bit 3 relaxed imbalance failure.
// - Group B bit 2 holds secondary protector failure.
// - Group B bit 1 discharge FET, bit 0 charge FET failure.
// - Group C bit 7 commanded failure, bit 6 comparator mux failure.
// - Group C bit 5 ground supply, bit 4 reference voltage failure.
// - Group C bit 3 holds slow oscillator monitor failure.
// - Group C bit 2 instruction ROM, bit 1 data ROM failure.
// - Group C bit 0 holds one-time memory failure.
// - Group D bit 0 top-of-stack failure; bits 7 to 1 read zero.
// - Manufacturing word is 16 bits; bits 15 to 8 and 3 read zero.
// - Bit 7 clear blocks runtime one-time memory programming; set allows it.
// - Runtime programming covers saved failure state and manufacturer data in full access.
// - Programming happens only with stack voltage and temperature in limits.
// - Configuration-update mode allows programming even with bit 7 clear.
// - Bit 6 clear disables permanent failure checks; set enables them.
// - Bit 4 clear selects FET test mode; FETs follow test bits only.
// - Bit 4 set keeps normal FET control and ignores test toggles.
// - In test mode safety may still force FETs off or diode-protect on.
// - Bits 5,2,1,0 show pre-discharge, discharge, charge, precharge test enables.
`default_nettype none
package fms_pkg;
   // Register byte addresses.
   localparam logic [7:0] FMS_FAULT_B_ADDR = 8'h00;
   localparam logic [7:0] FMS_FAULT_C_ADDR = 8'h04;
   localparam logic [7:0] FMS_FAULT_D_ADDR = 8'h08;
   localparam logic [7:0] FMS_MFG_ADDR     = 8'h0C;
   localparam logic [7:0] FMS_CMD_ADDR     = 8'h10;
   localparam logic [7:0] FMS_MODE_ADDR    = 8'h14;
   localparam logic [7:0] FMS_STAT_ADDR    = 8'h18;
   // Field positions, groups B, C and D.
   localparam int LATCHED_SHORT_DISCHARGE_FAIL_BIT = 7;
   localparam int IMBALANCE_ACTIVE_FAIL_BIT = 4;
   localparam int IMBALANCE_RELAX_FAIL_BIT = 3;
   localparam int SECONDARY_PROTECTOR_FAIL_BIT = 2;
   localparam int DISCHARGE_FET_FAIL_BIT = 1;
   localparam int CHARGE_FET_FAIL_BIT = 0;
   localparam int COMMANDED_FAIL_BIT = 7;
   localparam int COMPARATOR_MUX_FAIL_BIT = 6;
   localparam int GROUND_SUPPLY_FAIL_BIT = 5;
   localparam int REFERENCE_VOLTAGE_FAIL_BIT = 4;
   localparam int SLOW_OSCILLATOR_FAIL_BIT = 3;
   localparam int INSTRUCTION_ROM_FAIL_BIT = 2;
   localparam int DATA_ROM_FAIL_BIT = 1;
   localparam int ONETIME_MEMORY_FAIL_BIT = 0;
   localparam int TOP_OF_STACK_FAIL_BIT = 0;
   localparam logic [7:0] FMS_B_USED = 8'h9F;
   localparam logic [7:0] FMS_C_USED = 8'hFF;
   localparam logic [7:0] FMS_D_USED = 8'h01;
   // Manufacturing word fields.
   localparam int RUNTIME_PROGRAM_ENABLE_BIT = 7;
   localparam int PERMANENT_FAIL_CHECK_ENABLE_BIT = 6;
   localparam int PREDISCHARGE_TEST_ON_BIT = 5;
   localparam int NORMAL_FET_CONTROL_SELECT_BIT = 4;
   localparam int DISCHARGE_TEST_ON_BIT = 2;
   localparam int CHARGE_TEST_ON_BIT = 1;
   localparam int PRECHARGE_TEST_ON_BIT = 0;
   localparam logic [15:0] FMS_MFG_USED = 16'h00F7;
   localparam logic [15:0] FMS_MFG_RESET = 16'h0050;
   // FET vector order: 3 pre-discharge, 2 discharge, 1 charge, 0 precharge.
   localparam int FMS_FET_PDSG = 3;
   localparam int FMS_FET_DSG = 2;
   localparam int FMS_FET_CHG = 1;
   localparam int FMS_FET_PCHG = 0;
   // Mode register fields.
   localparam int FMS_MODE_CFG_UPDATE_BIT = 0;
   localparam int FMS_MODE_FULL_ACCESS_BIT = 1;
   localparam logic [1:0] FMS_MODE_RESET = 2'h0;
   typedef enum logic [7:0] {
      FMS_CMD_NONE      = 8'h00,
      FMS_CMD_PDSG_TGL  = 8'h01,
      FMS_CMD_DSG_TGL   = 8'h02,
      FMS_CMD_CHG_TGL   = 8'h03,
      FMS_CMD_PCHG_TGL  = 8'h04,
      FMS_CMD_FET_TGL   = 8'h05,
      FMS_CMD_PF_TGL    = 8'h06,
      FMS_CMD_OTPW_TGL  = 8'h07,
      FMS_CMD_CLR_FAULT = 8'h08
   } fms_cmd_e;
endpackage : fms_pkg
`default_nettype wire

//--- logic/fms_fault_if.sv
`default_nettype none
// One saved fault byte: detection pulses in, saved flags out.
interface fms_fault_if;
   logic [7:0] detect;
   logic       arm;
   logic       clear;
   logic [7:0] saved;
   modport owner (input detect, input arm, input clear, output saved);
   modport user  (output detect, output arm, output clear, input saved);
endinterface : fms_fault_if
`default_nettype wire

//--- logic/fms_fault_reg.sv
`default_nettype none
module fms_fault_reg
   import fms_pkg::*;
#(
   parameter logic [7:0] USED = 8'hFF       // Implemented flag bits.
)
(
   input wire logic    pclk,                // Bus clock.
   input wire logic    presetn,             // Async reset, active low.
   fms_fault_if.owner  f                    // Detect and saved flags.
);
   // A detect in the clear cycle still lands, so no failure is lost.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         f.saved <= 8'h00;
      end
      else
      begin
         f.saved <= ((f.clear ? 8'h00 : f.saved) | (f.arm ? f.detect : 8'h00)) & USED;
      end
   end
endmodule : fms_fault_reg
`default_nettype wire

//--- logic/fms_fet_test.sv
`default_nettype none
module fms_fet_test
   import fms_pkg::*;
(
   input wire logic       pclk,             // Bus clock.
   input wire logic       presetn,          // Async reset, active low.
   input wire logic       normal_sel,       // Normal FET control selected.
   input wire logic [3:0] test_on,          // Test enables from the word.
   input wire logic [3:0] normal_on,        // Normal control requests.
   input wire logic [3:0] safety_off,       // Safety forced off.
   input wire logic [3:0] diode_on,         // Body diode protection on.
   output logic     [3:0] fet_drive         // Registered FET drives.
);
   logic [3:0] next_fet_drive;

   // Safety overrides sit after the mode mux so test mode cannot defeat them.
   always_comb
   begin
      next_fet_drive = normal_sel ? normal_on : test_on;
      next_fet_drive = (next_fet_drive & ~safety_off) | diode_on;
   end

   // Drive register.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fet_drive <= 4'h0;
      end
      else
      begin
         fet_drive <= next_fet_drive;
      end
   end
endmodule : fms_fet_test
`default_nettype wire

//--- logic/fms_top.sv
`default_nettype none
module fms_top
   import fms_pkg::*;
(
   input wire logic        pclk,                         // Bus clock, 25 MHz.
   input wire logic        presetn,                      // Async reset, active low.
   input wire logic        psel,                         // APB select.
   input wire logic        penable,                      // APB enable.
   input wire logic        pwrite,                       // APB direction.
   input wire logic [7:0]  paddr,                        // APB byte address.
   input wire logic [31:0] pwdata,                       // APB write data.
   output logic     [31:0] prdata,                       // APB read data.
   output logic            pready,                       // APB ready.
   output logic            pslverr,                      // APB error.
   input wire logic        latched_short_discharge_fail, // Detect pulse.
   input wire logic        imbalance_active_fail,        // Detect pulse.
   input wire logic        imbalance_relax_fail,         // Detect pulse.
   input wire logic        secondary_protector_fail,     // Detect pulse.
   input wire logic        discharge_fet_fail,           // Detect pulse.
   input wire logic        charge_fet_fail,              // Detect pulse.
   input wire logic        commanded_fail,               // Detect pulse.
   input wire logic        comparator_mux_fail,          // Detect pulse.
   input wire logic        ground_supply_fail,           // Detect pulse.
   input wire logic        reference_voltage_fail,       // Detect pulse.
   input wire logic        slow_oscillator_fail,         // Detect pulse.
   input wire logic        instruction_rom_fail,         // Detect pulse.
   input wire logic        data_rom_fail,                // Detect pulse.
   input wire logic        onetime_memory_fail,          // Detect pulse.
   input wire logic        top_of_stack_fail,            // Detect pulse.
   input wire logic        stack_ok,                     // Stack voltage in limits.
   input wire logic        temp_ok,                      // Temperature in limits.
   input wire logic        otp_req_saved_state,          // Save failure or fuse state.
   input wire logic        otp_req_manufacturer_data,    // Store manufacturer data.
   input wire logic [3:0]  normal_fet_on,                // Normal FET requests.
   input wire logic [3:0]  safety_fet_off,               // Safety forces off.
   input wire logic [3:0]  body_diode_fet_on,            // Diode protection on.
   output logic [3:0]      fet_drive,                    // FET drives.
   output logic            otp_program_grant,            // Programming allowed now.
   output logic            pf_check_active               // Failure checks running.
);
   fms_fault_if grp_b ();
   fms_fault_if grp_c ();
   fms_fault_if grp_d ();

   logic [15:0] mfg_word;
   logic [1:0]  mode;
   logic        cmd_valid;
   logic [7:0]  cmd_code;
   logic        access_cycle;
   logic        wr_take;
   logic        rd_take;
   logic        addr_hit;
   logic [31:0] next_prdata;
   logic        next_grant;
   logic        runtime_program_enable;
   logic        permanent_fail_check_enable;
   logic        normal_fet_control_select;
   logic        config_update_mode;
   logic        full_access_security_mode;
   logic [3:0]  test_on;
   logic        otp_request;

   // Field views of the manufacturing word.
   assign runtime_program_enable      = mfg_word[RUNTIME_PROGRAM_ENABLE_BIT];
   assign permanent_fail_check_enable = mfg_word[PERMANENT_FAIL_CHECK_ENABLE_BIT];
   assign normal_fet_control_select   = mfg_word[NORMAL_FET_CONTROL_SELECT_BIT];
   assign config_update_mode          = mode[FMS_MODE_CFG_UPDATE_BIT];
   assign full_access_security_mode   = mode[FMS_MODE_FULL_ACCESS_BIT];

   // Test enables gathered in FET vector order.
   assign test_on[FMS_FET_PDSG] = mfg_word[PREDISCHARGE_TEST_ON_BIT];
   assign test_on[FMS_FET_DSG]  = mfg_word[DISCHARGE_TEST_ON_BIT];
   assign test_on[FMS_FET_CHG]  = mfg_word[CHARGE_TEST_ON_BIT];
   assign test_on[FMS_FET_PCHG] = mfg_word[PRECHARGE_TEST_ON_BIT];

   // APB phase decode: a transfer completes when pready is seen high.
   assign access_cycle = psel & penable;
   assign wr_take      = access_cycle & pready & pwrite;
   assign rd_take      = access_cycle & ~pready & ~pwrite;

   // Address map check.
   always_comb
   begin
      case (paddr)
         FMS_FAULT_B_ADDR: addr_hit = 1'b1;
         FMS_FAULT_C_ADDR: addr_hit = 1'b1;
         FMS_FAULT_D_ADDR: addr_hit = 1'b1;
         FMS_MFG_ADDR:     addr_hit = 1'b1;
         FMS_CMD_ADDR:     addr_hit = 1'b1;
         FMS_MODE_ADDR:    addr_hit = 1'b1;
         FMS_STAT_ADDR:    addr_hit = 1'b1;
         default:          addr_hit = 1'b0;
      endcase
   end

   // Group B detect bits; reserved bits 6 and 5 never set.
   always_comb
   begin
      grp_b.detect = 8'h00;
      grp_b.detect[LATCHED_SHORT_DISCHARGE_FAIL_BIT] = latched_short_discharge_fail;
      grp_b.detect[IMBALANCE_ACTIVE_FAIL_BIT] = imbalance_active_fail;
      grp_b.detect[IMBALANCE_RELAX_FAIL_BIT] = imbalance_relax_fail;
      grp_b.detect[SECONDARY_PROTECTOR_FAIL_BIT] = secondary_protector_fail;
      grp_b.detect[DISCHARGE_FET_FAIL_BIT] = discharge_fet_fail;
      grp_b.detect[CHARGE_FET_FAIL_BIT] = charge_fet_fail;
   end

   // Group C detect bits.
   always_comb
   begin
      grp_c.detect = 8'h00;
      grp_c.detect[COMMANDED_FAIL_BIT] = commanded_fail;
      grp_c.detect[COMPARATOR_MUX_FAIL_BIT] = comparator_mux_fail;
      grp_c.detect[GROUND_SUPPLY_FAIL_BIT] = ground_supply_fail;
      grp_c.detect[REFERENCE_VOLTAGE_FAIL_BIT] = reference_voltage_fail;
      grp_c.detect[SLOW_OSCILLATOR_FAIL_BIT] = slow_oscillator_fail;
      grp_c.detect[INSTRUCTION_ROM_FAIL_BIT] = instruction_rom_fail;
      grp_c.detect[DATA_ROM_FAIL_BIT] = data_rom_fail;
      grp_c.detect[ONETIME_MEMORY_FAIL_BIT] = onetime_memory_fail;
   end

   // Group D carries a single flag; the rest stay zero.
   always_comb
   begin
      grp_d.detect = 8'h00;
      grp_d.detect[TOP_OF_STACK_FAIL_BIT] = top_of_stack_fail;
   end

   // Detection is only armed while checks are enabled, so a disabled
   // check cannot latch anything even if the detector still pulses.
   assign grp_b.arm = permanent_fail_check_enable;
   assign grp_c.arm = permanent_fail_check_enable;
   assign grp_d.arm = permanent_fail_check_enable;

   // The clear command wipes all saved groups at once.
   assign grp_b.clear = cmd_valid & (cmd_code == FMS_CMD_CLR_FAULT);
   assign grp_c.clear = cmd_valid & (cmd_code == FMS_CMD_CLR_FAULT);
   assign grp_d.clear = cmd_valid & (cmd_code == FMS_CMD_CLR_FAULT);

   fms_fault_reg #(.USED(FMS_B_USED)) u_grp_b
   (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (grp_b)
   );

   fms_fault_reg #(.USED(FMS_C_USED)) u_grp_c
   (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (grp_c)
   );

   fms_fault_reg #(.USED(FMS_D_USED)) u_grp_d
   (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (grp_d)
   );

   // Command strobe: a write to the command address is one subcommand.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_valid <= 1'b0;
         cmd_code  <= 8'h00;
      end
      else
      begin
         cmd_valid <= wr_take & (paddr == FMS_CMD_ADDR);
         cmd_code  <= pwdata[7:0];
      end
   end

   // Manufacturing word. Test toggles are dropped while normal control
   // is selected, so test bits set earlier are kept and arm a later entry.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mfg_word <= FMS_MFG_RESET;
      end
      else if (cmd_valid)
      begin
         case (cmd_code)
            FMS_CMD_PDSG_TGL:
            begin
               if (!normal_fet_control_select)
               begin
                  mfg_word[PREDISCHARGE_TEST_ON_BIT] <= ~mfg_word[PREDISCHARGE_TEST_ON_BIT];
               end
            end
            FMS_CMD_DSG_TGL:
            begin
               if (!normal_fet_control_select)
               begin
                  mfg_word[DISCHARGE_TEST_ON_BIT] <= ~mfg_word[DISCHARGE_TEST_ON_BIT];
               end
            end
            FMS_CMD_CHG_TGL:
            begin
               if (!normal_fet_control_select)
               begin
                  mfg_word[CHARGE_TEST_ON_BIT] <= ~mfg_word[CHARGE_TEST_ON_BIT];
               end
            end
            FMS_CMD_PCHG_TGL:
            begin
               if (!normal_fet_control_select)
               begin
                  mfg_word[PRECHARGE_TEST_ON_BIT] <= ~mfg_word[PRECHARGE_TEST_ON_BIT];
               end
            end
            FMS_CMD_FET_TGL:
            begin
               mfg_word[NORMAL_FET_CONTROL_SELECT_BIT] <= ~normal_fet_control_select;
            end
            FMS_CMD_PF_TGL:
            begin
               mfg_word[PERMANENT_FAIL_CHECK_ENABLE_BIT] <= ~permanent_fail_check_enable;
            end
            FMS_CMD_OTPW_TGL:
            begin
               mfg_word[RUNTIME_PROGRAM_ENABLE_BIT] <= ~runtime_program_enable;
            end
            default:
            begin
               mfg_word <= mfg_word & FMS_MFG_USED;
            end
         endcase
      end
   end

   // Security and update mode register, written by software.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode <= FMS_MODE_RESET;
      end
      else if (wr_take && (paddr == FMS_MODE_ADDR))
      begin
         mode <= pwdata[1:0];
      end
   end

   // Only two kinds of runtime data may be programmed; manufacturer data
   // also needs full access.
   assign otp_request = otp_req_saved_state |
                        (otp_req_manufacturer_data & full_access_security_mode);

   // Grant logic: limits always apply, even in configuration update mode.
   always_comb
   begin
      next_grant = otp_request & stack_ok & temp_ok;
      next_grant = next_grant & (runtime_program_enable | config_update_mode);
   end

   // Registered side outputs.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         otp_program_grant <= 1'b0;
         pf_check_active   <= 1'b0;
      end
      else
      begin
         otp_program_grant <= next_grant;
         pf_check_active   <= permanent_fail_check_enable;
      end
   end

   fms_fet_test u_fet
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .normal_sel (normal_fet_control_select),
      .test_on    (test_on),
      .normal_on  (normal_fet_on),
      .safety_off (safety_fet_off),
      .diode_on   (body_diode_fet_on),
      .fet_drive  (fet_drive)
   );

   // Read mux; reserved bits are zero by construction.
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         FMS_FAULT_B_ADDR: next_prdata[7:0] = grp_b.saved;
         FMS_FAULT_C_ADDR: next_prdata[7:0] = grp_c.saved;
         FMS_FAULT_D_ADDR: next_prdata[7:0] = grp_d.saved;
         FMS_MFG_ADDR:     next_prdata[15:0] = mfg_word & FMS_MFG_USED;
         FMS_MODE_ADDR:    next_prdata[1:0] = mode;
         FMS_STAT_ADDR:
         begin
            next_prdata[0] = otp_program_grant;
            next_prdata[1] = pf_check_active;
            next_prdata[5:2] = fet_drive;
         end
         default:          next_prdata = 32'h0000_0000;
      endcase
   end

   // APB answer: one wait state, then ready with data or error.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (access_cycle && !pready)
      begin
         pready  <= 1'b1;
         pslverr <= ~addr_hit;
         prdata  <= rd_take ? next_prdata : 32'h0000_0000;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end
endmodule : fms_top
`default_nettype wire

//--- test/fms_top_props.sv
`default_nettype none
module fms_top_props
   import fms_pkg::*;
(
   input wire logic        pclk, // Clock.
   input wire logic        presetn, // Reset, active low.
   input wire logic        psel, // Select.
   input wire logic        penable, // Enable.
   input wire logic        pwrite, // Direction.
   input wire logic [7:0]  paddr, // Address.
   input wire logic [31:0] prdata, // Read data.
   input wire logic        pready, // Ready.
   input wire logic        pslverr, // Error.
   input wire logic        stack_ok, // Voltage in limits.
   input wire logic        temp_ok, // Temperature in limits.
   input wire logic        otp_req_saved_state, // Request.
   input wire logic        otp_req_manufacturer_data, // Request.
   input wire logic [3:0]  safety_fet_off, // Forced off.
   input wire logic [3:0]  body_diode_fet_on, // Forced on.
   input wire logic [3:0]  fet_drive, // Drives.
   input wire logic        otp_program_grant // Grant.
);
   // One clock; checks sleep in reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Read answer qualifier.
   wire rd_ack = pready & ~pwrite;
   chk_ready_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("ready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   chk_error_decode: assert property (pready |->
      pslverr == (paddr > FMS_STAT_ADDR || paddr[1:0] != 2'b00)) else $error("bad error flag");
   chk_idle_data: assert property (!pready |-> prdata == 32'h0)
      else $error("stray read data");
   chk_word_reserved: assert property (rd_ack && paddr == FMS_MFG_ADDR |->
      (prdata & ~32'h0000_00F7) == 32'h0) else $error("word bits set");
   chk_group_d_bits: assert property (rd_ack && paddr == FMS_FAULT_D_ADDR |->
      prdata[31:1] == 31'h0) else $error("group d bits set");
   chk_grant_limits: assert property (otp_program_grant |-> $past(stack_ok && temp_ok))
      else $error("grant out of limits");
   chk_grant_request: assert property (otp_program_grant |->
      $past(otp_req_saved_state || otp_req_manufacturer_data)) else $error("stray grant");
   chk_fet_forced: assert property ($past(presetn) |->
      (fet_drive & $past(safety_fet_off & ~body_diode_fet_on)) == 4'h0)
      else $error("fet not forced off");
   chk_fet_diode: assert property ($past(presetn) |->
      ($past(body_diode_fet_on) & ~fet_drive) == 4'h0) else $error("diode fet off");
   cover property (pslverr);
   cover property (otp_program_grant);
   cover property (fet_drive == 4'hF);
endmodule : fms_top_props
bind fms_top fms_top_props i_props (.*);
`default_nettype wire

//--- test/fms_host_model.sv
`default_nettype none
module fms_host_model
   import fms_pkg::*;
(
   input wire logic        pclk,    // Bus clock.
   output logic            psel,    // Select.
   output logic            penable, // Enable.
   output logic            pwrite,  // Direction.
   output logic [7:0]      paddr,   // Address.
   output logic [31:0]     pwdata,  // Write data.
   input wire logic [31:0] prdata,  // Read data.
   input wire logic        pready,  // Ready.
   input wire logic        pslverr  // Error.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero.
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer; released address and data show inverses, pwrite keeps its stale value.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
      @(posedge pclk);
   endtask : xfer
   // Command, then read the word back.
   task command(input logic [7:0] c, output logic [31:0] word);
      logic e;
      xfer(1'b1, FMS_CMD_ADDR, {24'h00, c}, word, e);
      xfer(1'b0, FMS_MFG_ADDR, 32'h0, word, e);
   endtask : command
endmodule : fms_host_model
`default_nettype wire

//--- test/fms_top_tb.sv
`default_nettype none
module fms_top_tb
   import fms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        stack_ok, temp_ok, otp_program_grant, pf_check_active;
   logic        otp_req_saved_state, otp_req_manufacturer_data;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  normal_fet_on, safety_fet_off, body_diode_fet_on, fet_drive;
   logic [14:0] fault_in;
   int          err_count, checks_done, cycles;
   // Fault vector: 14..9 group b flags, 8..1 group c, 0 group d.
   fms_top i_dut (.*, .latched_short_discharge_fail(fault_in[14]),
      .imbalance_active_fail(fault_in[13]), .imbalance_relax_fail(fault_in[12]),
      .secondary_protector_fail(fault_in[11]), .discharge_fet_fail(fault_in[10]),
      .charge_fet_fail(fault_in[9]), .commanded_fail(fault_in[8]),
      .comparator_mux_fail(fault_in[7]), .ground_supply_fail(fault_in[6]),
      .reference_voltage_fail(fault_in[5]), .slow_oscillator_fail(fault_in[4]),
      .instruction_rom_fail(fault_in[3]), .data_rom_fail(fault_in[2]),
      .onetime_memory_fail(fault_in[1]), .top_of_stack_fail(fault_in[0]));
   fms_host_model i_host (.*);
   // Clock at 25 MHz.
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         err_count++;
         stop_test();
      end
   end
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task check(logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task tick(int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   task wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b1, a, d, r, e);
   endtask : wr
   task rd_chk(logic [7:0] a, logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask : rd_chk
   task cmd_chk(logic [7:0] c, logic [15:0] exp);
      logic [31:0] w;
      i_host.command(c, w);
      check(w, {16'h0, exp});
   endtask : cmd_chk
   task fet_is(logic [3:0] exp);
      tick(3);
      check({28'h0, fet_drive}, {28'h0, exp});
   endtask : fet_is
   task faults_zero;
      for (int a = 0; a < 12; a += 4) rd_chk(8'(a), 32'h0);
   endtask : faults_zero
   // Bits: stack, temperature, saved request, data request, mode.
   task otp_row(logic [5:0] v, logic exp);
      wr(FMS_MODE_ADDR, {30'h0, v[1:0]});
      {stack_ok, temp_ok, otp_req_saved_state, otp_req_manufacturer_data} <= v[5:2];
      tick(3);
      check({31'h0, otp_program_grant}, {31'h0, exp});
   endtask : otp_row
   task t_faults;
      logic [14:0] acc;
      acc = '0;
      faults_zero();
      rd_chk(FMS_MFG_ADDR, 32'h0000_0050);
      for (int i = 14; i >= 0; i--)
      begin
         fault_in <= 15'h0001 << i;
         tick(1);
         fault_in <= 15'h0000;
         acc[i] = 1'b1;
         tick(2);
         rd_chk(FMS_FAULT_B_ADDR, {24'h0, acc[14], 2'b00, acc[13:9]});
         rd_chk(FMS_FAULT_C_ADDR, {24'h0, acc[8:1]});
         rd_chk(FMS_FAULT_D_ADDR, {31'h0, acc[0]});
      end
      cmd_chk(8'h08, 16'h0050);
      faults_zero();
      $display("fault test done");
   endtask : t_faults
   task t_pf_off;
      cmd_chk(8'h06, 16'h0010);
      check({31'h0, pf_check_active}, 32'h0);
      fault_in <= 15'h7FFF;
      tick(2);
      fault_in <= 15'h0000;
      faults_zero();
      cmd_chk(8'h06, 16'h0050);
      check({31'h0, pf_check_active}, 32'h1);
      $display("check enable test done");
   endtask : t_pf_off
   task t_fet;
      logic [15:0] w;
      logic [3:0]  f;
      normal_fet_on <= 4'hA;
      cmd_chk(8'h01, 16'h0050);
      fet_is(4'hA);
      cmd_chk(8'h05, 16'h0040);
      fet_is(4'h0);
      {w, f} = {16'h0040, 4'h0};
      for (int k = 0; k < 4; k++)
      begin
         w[k == 0 ? 5 : 3 - k] = 1'b1;
         f[3 - k] = 1'b1;
         cmd_chk(8'(k + 1), w);
         fet_is(f);
      end
      {safety_fet_off, body_diode_fet_on} <= 8'h50;
      fet_is(4'hA);
      {safety_fet_off, body_diode_fet_on} <= 8'hF2;
      fet_is(4'h2);
      {safety_fet_off, body_diode_fet_on} <= 8'h00;
      cmd_chk(8'h05, 16'h0077);
      rd_chk(FMS_STAT_ADDR, 32'h0000_002A);
      $display("fet test done");
   endtask : t_fet
   task t_otp;
      otp_row(6'b111000, 1'b0);
      otp_row(6'b111001, 1'b1);
      cmd_chk(8'h07, 16'h00F7);
      otp_row(6'b111000, 1'b1);
      otp_row(6'b011000, 1'b0);
      otp_row(6'b101000, 1'b0);
      otp_row(6'b110100, 1'b0);
      otp_row(6'b110110, 1'b1);
      otp_row(6'b110000, 1'b0);
      $display("program grant test done");
   endtask : t_otp
   task t_bus;
      logic [31:0] r;
      logic        e;
      i_host.xfer(1'b1, 8'h1C, 32'hFFFF_FFFF, r, e);
      check({31'h0, e}, 32'h1);
      wr(FMS_MFG_ADDR, 32'h0);
      rd_chk(FMS_MFG_ADDR, 32'h0000_00F7);
      wr(FMS_FAULT_D_ADDR, 32'h0000_00FF);
      rd_chk(FMS_FAULT_D_ADDR, 32'h0);
      $display("bus test done");
   endtask : t_bus
   // Reset for five cycles, then each scenario.
   initial
   begin
      presetn = 1'b0;
      {fault_in, stack_ok, temp_ok, otp_req_saved_state, otp_req_manufacturer_data} = '0;
      {normal_fet_on, safety_fet_off, body_diode_fet_on} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_faults();
      t_pf_off();
      t_fet();
      t_otp();
      t_bus();
      stop_test();
   end
endmodule : fms_top_tb
`default_nettype wire
